// >>> verilog/dcc_pkg.sv
package dcc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_SYS_CLK_DIV = 8'h00_d4;
    localparam logic [7:0] ADDR_STOP_KEY = 8'h00_f5;
    localparam logic [7:0] ADDR_OSC_SEL = 8'h00_80;
    localparam logic [7:0] ADDR_CLK_STATUS = 8'h00_81;

    // Field positions
    localparam int DIV_LSB = 3;
    localparam int DIV_MSB = 4;
    localparam int OSC_SRC_BIT = 0;
    localparam int SUB_STOP_BIT = 2;
    localparam int MAIN_STOP_BIT = 3;

    // Reset values
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [7:0] KEY_RESET = 8'h00_00;
    localparam logic OSC_SRC_RESET = 1'b0;
    localparam logic SUB_STOP_RESET = 1'b0;
    localparam logic MAIN_STOP_RESET = 1'b0;

    // Only this key value unlocks the stop instruction
    localparam logic [7:0] STOP_KEY_OPEN = 8'h00_a5;

    // Divider encodings and their terminal counts
    localparam logic [1:0] DIV_BY_16 = 2'h0;
    localparam logic [1:0] DIV_BY_8 = 2'h1;
    localparam logic [1:0] DIV_BY_2 = 2'h2;
    localparam logic [1:0] DIV_BY_1 = 2'h3;
    localparam logic [3:0] TERM_16 = 4'h000f;
    localparam logic [3:0] TERM_8 = 4'h0007;
    localparam logic [3:0] TERM_2 = 4'h0001;
    localparam logic [3:0] TERM_1 = 4'h0000;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_STOP = 2'b10
    } dcc_mode_e;

    // Register port request from the CPU side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dcc_bus_s;

    // Power-down requests and wake-up sources
    typedef struct packed {
        logic stop_req;
        logic idle_req;
        logic ext_int;
        logic int_int;
        logic wt_on_sub;
    } dcc_pm_s;

endpackage

// >>> verilog/dcc_clock_control.sv
// Overview of operation
// - CPU clock is selected clock divided by 1, 2, 8 or 16 only.
// - After main oscillator starts, CPU runs at selected clock over 16.
// - Divider bits 4:3 choose ratio; sub clock needs them at 11 (not enforced: the sub clock runs at any ratio).
// - Select bit 0: zero picks main clock, one picks sub clock.
// - Select bit 3: zero runs main oscillator, one stops it.
// - Select bit 2 starts or stops the sub oscillator independently.
// - Stop halts main oscillator; reset or external interrupt wakes.
// - Internal interrupt wakes Stop only with sub clock watch timer.
// - Idle gates CPU clock only; any interrupt or reset wakes it.
// - Stop instruction works only while the key holds 10100101B.
// - Divider register is read/write at address D4H.
// - Stop key register is read/write at address F5H.
module dcc_clock_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dcc_pkg::dcc_bus_s bus_i,
    input wire dcc_pkg::dcc_pm_s pm_i,
    input wire logic main_clock_i,
    input wire logic sub_clock_i,
    output logic [7:0] rd_data_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic main_osc_en_o,
    output logic sub_osc_en_o,
    output logic stop_mode_o,
    output logic idle_mode_o
);

    // Clocking scheme: the oscillator pins are sampled on clk_i and turned
    // into one-cycle ticks, so every divided clock is an enable pulse.
    // Limitation: each oscillator phase must last at least two clk_i
    // cycles, or edges are lost in the sampling chain.
    // Trade-off: enables instead of gated clocks keep one clock domain,
    // at the cost of a few cycles of latency after each pin edge.
    // Source and ratio changes are latched at a divider wrap, or at once if the active source is stopped.

    // Whole state of the block
    typedef struct packed {
        // Software-visible register bits
        logic [1:0] div_sel;
        logic [7:0] stop_key;
        logic src_sub;
        logic sub_stop;
        logic main_stop;
        // Selection in force and the divider count
        logic act_sub;
        logic [1:0] act_div;
        logic [3:0] cnt;
        // Power-down mode
        dcc_pkg::dcc_mode_e mode;
        // Pin sampling chains and filtered levels
        logic [2:0] main_sync;
        logic [2:0] sub_sync;
        logic main_lvl;
        logic sub_lvl;
        // Registered outputs
        logic cpu_en;
        logic per_en;
        logic [7:0] rd_data;
        // Oscillator run enables
        logic main_on;
        logic sub_on;
    } dcc_state_s;

    dcc_state_s st;
    dcc_state_s next_st;

    // Oscillator ticks and the one of the selected source
    logic main_tick;
    logic sub_tick;
    logic sys_tick;
    // Terminal count of the ratio in force
    logic [3:0] term;
    // Power-down decisions
    logic wake_stop;
    logic wake_idle;
    logic stop_open;

    // Oscillator edges, taken once the two late sync stages agree
    // A disabled oscillator gives no tick, so a stopping oscillator
    // cannot deliver a late edge into the divider
    always_comb begin
        main_tick = 1'b0;
        sub_tick = 1'b0;
        if (st.main_sync[1] == st.main_sync[2]) begin
            main_tick = st.main_sync[2] & ~st.main_lvl & st.main_on;
        end
        if (st.sub_sync[1] == st.sub_sync[2]) begin
            sub_tick = st.sub_sync[2] & ~st.sub_lvl & st.sub_on;
        end
    end

    // Tick of the selected system clock
    // source mux
    assign sys_tick = st.act_sub ? sub_tick : main_tick;

    // Terminal count of the active ratio
    // Decoded from the latched copy, never straight from the register
    // ratio decode
    always_comb begin
        unique case (st.act_div)
            dcc_pkg::DIV_BY_16: term = dcc_pkg::TERM_16;
            dcc_pkg::DIV_BY_8: term = dcc_pkg::TERM_8;
            dcc_pkg::DIV_BY_2: term = dcc_pkg::TERM_2;
            dcc_pkg::DIV_BY_1: term = dcc_pkg::TERM_1;
        endcase
    end

    // Stop entry is locked unless the key holds the exact value
    // Any other value, the reset value included, keeps Stop locked
    // key check
    assign stop_open = (st.stop_key == dcc_pkg::STOP_KEY_OPEN);

    // Wake sources; reset wakes every mode through rst_i itself
    // Idle wakes on any interrupt; Stop takes an internal one only
    // while the watch timer runs from a live sub oscillator
    // external wake
    assign wake_stop = pm_i.ext_int
        | (pm_i.int_int & st.sub_on & pm_i.wt_on_sub);
    assign wake_idle = pm_i.ext_int | pm_i.int_int;

    // Next state
    always_comb begin
        next_st = st;

        // Three-stage sampling of the oscillator inputs
        // Stage 0 may go metastable, so only stages 1 and 2 are compared
        // The filtered level follows only when both late stages agree
        next_st.main_sync = {st.main_sync[1:0], main_clock_i};
        next_st.sub_sync = {st.sub_sync[1:0], sub_clock_i};
        if (st.main_sync[1] == st.main_sync[2]) begin
            next_st.main_lvl = st.main_sync[2];
        end
        if (st.sub_sync[1] == st.sub_sync[2]) begin
            next_st.sub_lvl = st.sub_sync[2];
        end

        // Register writes
        // Unmapped addresses fall through and are ignored
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                dcc_pkg::ADDR_SYS_CLK_DIV: begin
                    next_st.div_sel =
                        bus_i.wdata[dcc_pkg::DIV_MSB:dcc_pkg::DIV_LSB];
                end
                dcc_pkg::ADDR_STOP_KEY: begin
                    next_st.stop_key = bus_i.wdata;
                end
                dcc_pkg::ADDR_OSC_SEL: begin
                    next_st.src_sub = bus_i.wdata[dcc_pkg::OSC_SRC_BIT];
                    next_st.sub_stop = bus_i.wdata[dcc_pkg::SUB_STOP_BIT];
                    next_st.main_stop = bus_i.wdata[dcc_pkg::MAIN_STOP_BIT];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data valid in the following cycle only
        // Unmapped addresses and reserved bits read as zero
        next_st.rd_data = 8'h00_00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                dcc_pkg::ADDR_SYS_CLK_DIV: begin
                    next_st.rd_data[dcc_pkg::DIV_MSB:dcc_pkg::DIV_LSB] =
                        st.div_sel;
                end
                dcc_pkg::ADDR_STOP_KEY: begin
                    next_st.rd_data = st.stop_key;
                end
                dcc_pkg::ADDR_OSC_SEL: begin
                    next_st.rd_data[dcc_pkg::OSC_SRC_BIT] = st.src_sub;
                    next_st.rd_data[dcc_pkg::SUB_STOP_BIT] = st.sub_stop;
                    next_st.rd_data[dcc_pkg::MAIN_STOP_BIT] = st.main_stop;
                end
                dcc_pkg::ADDR_CLK_STATUS: begin
                    next_st.rd_data = {st.sub_on, st.main_on, st.mode,
                        1'b0, st.act_div, st.act_sub};
                end
                default: begin
                end
            endcase
        end

        // Power-down mode sequencing
        // Requests are taken only in run; a locked stop request is dropped
        // A Stop wake also restarts the main oscillator below, unless
        // software has its own stop bit set
        unique case (st.mode)
            dcc_pkg::MODE_RUN: begin
                if (pm_i.stop_req && stop_open) begin
                    next_st.mode = dcc_pkg::MODE_STOP;
                end else if (pm_i.idle_req) begin
                    next_st.mode = dcc_pkg::MODE_IDLE;
                end
            end
            dcc_pkg::MODE_IDLE: begin
                if (wake_idle) begin
                    next_st.mode = dcc_pkg::MODE_RUN;
                end
            end
            dcc_pkg::MODE_STOP: begin
                if (wake_stop) begin
                    next_st.mode = dcc_pkg::MODE_RUN;
                end
            end
            default: begin
                next_st.mode = dcc_pkg::MODE_RUN;
            end
        endcase

        // Oscillator enables; Stop overrides the main run bit
        // The sub oscillator keeps running in Stop for the watch timer
        // halt main osc
        next_st.main_on = ~next_st.main_stop
            & (next_st.mode != dcc_pkg::MODE_STOP);
        next_st.sub_on = ~next_st.sub_stop;

        // Divider; new source and ratio are taken at wrap, or at once below when the active source is dead
        next_st.cpu_en = 1'b0;
        next_st.per_en = 1'b0;
        // Gate with the mode being entered, so that no CPU tick leaks into
        // the first cycle of Idle or Stop, nor a peripheral tick into Stop
        if (sys_tick) begin
            next_st.per_en = (next_st.mode != dcc_pkg::MODE_STOP);
            if (st.cnt >= term) begin
                next_st.cnt = 4'h0000;
                next_st.cpu_en = (next_st.mode == dcc_pkg::MODE_RUN);
                next_st.act_sub = st.src_sub;
                next_st.act_div = st.div_sel;
            end else begin
                next_st.cnt = st.cnt + 4'h0001;
            end
        end

        // A dead selected source would freeze the divider forever
        // so the pending selection is taken at once, from a count of zero
        // idle source switch
        if (!(st.act_sub ? st.sub_on : st.main_on)) begin
            next_st.act_sub = st.src_sub;
            next_st.act_div = st.div_sel;
            next_st.cnt = 4'h0000;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.div_sel <= dcc_pkg::DIV_RESET;
            st.act_div <= dcc_pkg::DIV_RESET;
            st.stop_key <= dcc_pkg::KEY_RESET;
            st.src_sub <= dcc_pkg::OSC_SRC_RESET;
            st.act_sub <= dcc_pkg::OSC_SRC_RESET;
            st.sub_stop <= dcc_pkg::SUB_STOP_RESET;
            st.main_stop <= dcc_pkg::MAIN_STOP_RESET;
            st.cnt <= 4'h0000;
            st.mode <= dcc_pkg::MODE_RUN;
            // Sampling chains start from a low pin
            st.main_sync <= 3'h0;
            st.sub_sync <= 3'h0;
            st.main_lvl <= 1'b0;
            st.sub_lvl <= 1'b0;
            // No tick and no read data while in reset
            st.cpu_en <= 1'b0;
            st.per_en <= 1'b0;
            st.rd_data <= 8'h00_00;
            // Both oscillators run out of reset
            st.main_on <= ~dcc_pkg::MAIN_STOP_RESET;
            st.sub_on <= ~dcc_pkg::SUB_STOP_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    // Read data is zero outside its one-cycle slot
    assign rd_data_o = st.rd_data;
    assign cpu_clk_en_o = st.cpu_en;
    assign periph_clk_en_o = st.per_en;
    assign main_osc_en_o = st.main_on;
    assign sub_osc_en_o = st.sub_on;
    // Mode codes give each mode output a single state bit of its own,
    // so both outputs come straight from a flop with no decode
    assign stop_mode_o = st.mode[1];
    assign idle_mode_o = st.mode[0];

endmodule

// >>> verification/dcc_clock_control_sva.sv
module dcc_clock_control_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dcc_pkg::dcc_bus_s bus_i,
    input wire dcc_pkg::dcc_pm_s pm_i,
    input wire logic main_clock_i,
    input wire logic sub_clock_i,
    input wire logic [7:0] rd_data_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic main_osc_en_o,
    input wire logic sub_osc_en_o,
    input wire logic stop_mode_o,
    input wire logic idle_mode_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Shadow of the key register, kept from the bus writes alone
    logic [7:0] key_copy;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_copy <= dcc_pkg::KEY_RESET;
        end else if (bus_i.wr && bus_i.addr == dcc_pkg::ADDR_STOP_KEY) begin
            key_copy <= bus_i.wdata;
        end
    end

    // Register port: data only after a read, exact read-back
    chk_rd_quiet: assert property (
        rd_data_o != 8'h00 |-> $past(bus_i.rd))
        else $error("read data outside read slot");
    chk_key_back: assert property (
        bus_i.wr && bus_i.addr == dcc_pkg::ADDR_STOP_KEY ##2
        bus_i.rd && bus_i.addr == dcc_pkg::ADDR_STOP_KEY
        |=> rd_data_o == $past(bus_i.wdata, 3))
        else $error("stop key read-back wrong");
    chk_div_back: assert property (
        bus_i.wr && bus_i.addr == dcc_pkg::ADDR_SYS_CLK_DIV ##2
        bus_i.rd && bus_i.addr == dcc_pkg::ADDR_SYS_CLK_DIV
        |=> rd_data_o == ($past(bus_i.wdata, 3) & 8'h18))
        else $error("divider read-back wrong");

    // Stop entry only from a request, and it halts the main oscillator
    chk_stop_entry: assert property (
        $rose(stop_mode_o) |-> $past(pm_i.stop_req) && !main_osc_en_o)
        else $error("stop entry wrong");
    chk_stop_locked: assert property (
        $rose(stop_mode_o) |-> $past(key_copy) == dcc_pkg::STOP_KEY_OPEN)
        else $error("stop entered with a locked key");
    chk_idle_entry: assert property (
        $rose(idle_mode_o) |-> $past(pm_i.idle_req))
        else $error("idle entered without a request");
    chk_stop_gate: assert property (
        stop_mode_o |-> !periph_clk_en_o && !cpu_clk_en_o)
        else $error("clock tick during stop");
    chk_idle_gate: assert property (idle_mode_o |-> !cpu_clk_en_o)
        else $error("cpu tick during idle");
    chk_ext_wake: assert property (
        (stop_mode_o || idle_mode_o) && pm_i.ext_int
        |=> !stop_mode_o && !idle_mode_o)
        else $error("external interrupt did not wake");
    chk_int_hold: assert property (
        stop_mode_o && pm_i.int_int && !pm_i.wt_on_sub && !pm_i.ext_int
        |=> stop_mode_o)
        else $error("internal interrupt woke stop wrongly");
    // CPU ticks are a subset of system clock ticks, never a stray pulse
    chk_tick_pair: assert property (cpu_clk_en_o |-> periph_clk_en_o)
        else $error("cpu tick without system tick");
endmodule

bind dcc_clock_control dcc_clock_control_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .pm_i(pm_i),
    .main_clock_i(main_clock_i), .sub_clock_i(sub_clock_i),
    .rd_data_o(rd_data_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .main_osc_en_o(main_osc_en_o),
    .sub_osc_en_o(sub_osc_en_o), .stop_mode_o(stop_mode_o),
    .idle_mode_o(idle_mode_o)
);

// >>> verification/tb_dcc_clock_control.sv
module tb_dcc_clock_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i;
    // Pins start low; only the pin process below drives them afterwards
    logic main_clock_i = 1'b0;
    logic sub_clock_i = 1'b0;
    dcc_pkg::dcc_bus_s bus_i;
    dcc_pkg::dcc_pm_s pm_i;
    logic [7:0] rd_data_o, n;
    logic cpu_clk_en_o, periph_clk_en_o, main_osc_en_o, sub_osc_en_o;
    logic stop_mode_o, idle_mode_o;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int r[4] = '{16, 8, 2, 1};

    dcc_clock_control DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
        .pm_i(pm_i), .main_clock_i(main_clock_i), .sub_clock_i(sub_clock_i),
        .rd_data_o(rd_data_o), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .main_osc_en_o(main_osc_en_o),
        .sub_osc_en_o(sub_osc_en_o), .stop_mode_o(stop_mode_o),
        .idle_mode_o(idle_mode_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Oscillator pins kept well below clk/8; cycle ceiling cuts a hang
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc % 10 == 9) main_clock_i <= ~main_clock_i;
        if (cyc % 20 == 19) sub_clock_i <= ~sub_clock_i;
        if (cyc == 30000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Each access waits an edge first, so strobes never collide
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.wdata <= d;
        bus_i.wr <= 1'b1;
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.rd <= 1'b1;
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        @(negedge clk_i);
        check("read data", rd_data_o, exp);
    endtask

    // Power request or wake source held for one cycle
    task automatic pm(input logic [4:0] v);
        @(posedge clk_i);
        pm_i <= v;
        @(posedge clk_i);
        pm_i <= 5'h00;
        @(negedge clk_i);
    endtask

    // Skip two wraps so the new ratio is in force, then count ticks
    task automatic ratio(input logic [7:0] exp);
        repeat (2) do @(negedge clk_i); while (cpu_clk_en_o !== 1'b1);
        n = 8'h00;
        do begin
            @(negedge clk_i);
            n = n + 8'(periph_clk_en_o);
        end while (cpu_clk_en_o !== 1'b1);
        check("ratio", n, exp);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        bus_i = '0;
        pm_i = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dcc_pkg::ADDR_SYS_CLK_DIV, 8'h00);
        rd(dcc_pkg::ADDR_STOP_KEY, 8'h00);
        rd(dcc_pkg::ADDR_CLK_STATUS, 8'hc0);
        ratio(8'd16);
        wr(8'h90, 8'hff);
        rd(8'h90, 8'h00);
        $display("reset and map test done");
        for (int i = 0; i < 4; i++) begin
            wr(dcc_pkg::ADDR_SYS_CLK_DIV, 8'he7 | 8'(i << 3));
            rd(dcc_pkg::ADDR_SYS_CLK_DIV, 8'(i << 3));
            ratio(8'(r[i]));
        end
        $display("divider test done");
        wr(dcc_pkg::ADDR_OSC_SEL, 8'h04);
        check("sub run", sub_osc_en_o, 1'b0);
        check("main run", main_osc_en_o, 1'b1);
        rd(dcc_pkg::ADDR_OSC_SEL, 8'h04);
        wr(dcc_pkg::ADDR_OSC_SEL, 8'h01);
        ratio(8'd1);
        rd(dcc_pkg::ADDR_CLK_STATUS, 8'hc7);
        wr(dcc_pkg::ADDR_OSC_SEL, 8'h09);
        rd(dcc_pkg::ADDR_CLK_STATUS, 8'h87);
        check("main run", main_osc_en_o, 1'b0);
        wr(dcc_pkg::ADDR_OSC_SEL, 8'h01);
        repeat (40) @(posedge clk_i);
        wr(dcc_pkg::ADDR_OSC_SEL, 8'h00);
        ratio(8'd1);
        $display("source test done");
        wr(dcc_pkg::ADDR_STOP_KEY, 8'ha4);
        pm(5'h10);
        check("stop refused", stop_mode_o, 1'b0);
        wr(dcc_pkg::ADDR_STOP_KEY, 8'ha5);
        rd(dcc_pkg::ADDR_STOP_KEY, 8'ha5);
        for (int i = 0; i < 2; i++) begin
            pm(5'h10);
            check("stop", stop_mode_o, 1'b1);
            check("main run", main_osc_en_o, 1'b0);
            rd(dcc_pkg::ADDR_CLK_STATUS, 8'ha6);
            pm(5'h02);
            check("stop hold", stop_mode_o, 1'b1);
            pm(i == 0 ? 5'h04 : 5'h03);
            check("stop wake", stop_mode_o, 1'b0);
            check("main run", main_osc_en_o, 1'b1);
        end
        $display("stop test done");
        for (int i = 0; i < 2; i++) begin
            pm(5'h08);
            check("idle", idle_mode_o, 1'b1);
            n = 8'h00;
            repeat (60) begin
                @(negedge clk_i);
                n = n + 8'(periph_clk_en_o);
            end
            check("idle ticks", 8'(n != 8'h00), 8'h01);
            rd(dcc_pkg::ADDR_CLK_STATUS, 8'hd6);
            pm(i == 0 ? 5'h04 : 5'h02);
            check("idle wake", idle_mode_o, 1'b0);
        end
        $display("idle test done");
        close_out();
    end
endmodule
